// [src/conv_output_port.sv]
/*
 * Digital side of a 10-bit pipelined sampling converter: samples the
 * quantiser on each falling conversion-clock edge, clamps out-of-range
 * values, buffers samples in a FIFO and presents each word on a three-state
 * bus two conversion cycles later. Assumes the conversion clock, sleep
 * request and enable pins are asynchronous to clk_i, and that the quantiser
 * result is stable from the conversion clock's falling edge until that fall is detected.
 */
// What this block does
// - A sample is taken at each falling edge of the conversion clock.
// - A sample's word reaches the bus two conversion cycles after its falling edge.
// - A fresh word is presented every conversion cycle from the third falling edge after wake, once the pipe has filled.
// - Conversion runs only while the clock toggles and sleep request is low.
// - With enable low and sleep request low the bus is driven with the current word.
// - With enable or sleep request high every bus pin is released.
// - Under-range input gives an all-zero word.
// - Over-range input gives an all-one word.
// - Words are ten bits wide, codes 0 to 1023, at conversion rates up to a quarter of the clk_i rate, well below the rated maximum.
// - The bus changes only after a falling edge and the old word holds until then.
// - The new word is valid about four clk_i cycles after the edge, longer than the maximum clock to output delay.
// - Saturated words read 3FF for over-range and 000 for under-range.
module conv_output_port
    import conv_port_pkg::*;
#(
    parameter int FIFO_DEPTH_P = conv_port_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic                               clk_i,
    input  wire logic                               rst_i,
    // Pins from capture logic
    input  wire logic                               conv_clk_i,
    input  wire logic                               sleep_request_i,
    input  wire logic                               out_enable_n_i,
    // Quantiser result
    input  wire conv_port_pkg::sample_type          raw_sample_i,
    // Output bus
    output logic [conv_port_pkg::CODE_W-1:0]        data_o,
    output logic [conv_port_pkg::CODE_W-1:0]        data_oe_o,
    output logic                                    word_strobe_o,
    output logic                                    wake_done_o,
    output logic                                    overflow_o
);
    import conv_port_pkg::*;

    // ********************************************************************
    // Pin synchronisers
    // ********************************************************************
    logic [2:0] cclk_sync_r;
    logic [2:0] sleep_sync_r;
    logic [2:0] oen_sync_r;
    logic       cclk_lvl_r;
    logic       sleep_lvl_r;
    logic       oen_lvl_r;
    logic       fall_evt;

    // Later stages agree, so a pin change is taken as settled
    function automatic logic settled(input logic [2:0] s);
        return s[1] == s[2];
    endfunction

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cclk_sync_r  <= 3'h0;
            sleep_sync_r <= 3'h7;
            oen_sync_r   <= 3'h7;
        end else begin
            cclk_sync_r  <= {cclk_sync_r[1:0], conv_clk_i};
            sleep_sync_r <= {sleep_sync_r[1:0], sleep_request_i};
            oen_sync_r   <= {oen_sync_r[1:0], out_enable_n_i};
        end
    end

    // A change counts once the second and third stages agree
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cclk_lvl_r  <= 1'b0;
            sleep_lvl_r <= 1'b1;
            oen_lvl_r   <= 1'b1;
        end else begin
            if (settled(cclk_sync_r)) begin
                cclk_lvl_r <= cclk_sync_r[2];
            end
            if (settled(sleep_sync_r)) begin
                sleep_lvl_r <= sleep_sync_r[2];
            end
            if (settled(oen_sync_r)) begin
                oen_lvl_r <= oen_sync_r[2];
            end
        end
    end

    assign fall_evt = cclk_lvl_r && settled(cclk_sync_r) && !cclk_sync_r[2];

    // ********************************************************************
    // Clamp
    // ********************************************************************
    // ten-bit code out
    function automatic logic [CODE_W-1:0] clamp_code(input sample_type s);
        if (s.under) begin
            return CODE_ZERO;
        end else if (s.over) begin
            return CODE_FULL;
        end else begin
            return s.code;
        end
    endfunction

    // ********************************************************************
    // Run control
    // ********************************************************************
    run_state_type state_r;
    logic [1:0]    fill_cnt_r;
    logic [9:0]    wake_cnt_r;
    logic          running;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r    <= ST_SLEEP;
            fill_cnt_r <= 2'h0;
        end else begin
            case (state_r)
                ST_SLEEP: begin
                    fill_cnt_r <= 2'h0;
                    if (!sleep_lvl_r) begin
                        state_r <= ST_FILL;
                    end
                end
                ST_FILL: begin
                    if (sleep_lvl_r) begin
                        state_r <= ST_SLEEP;
                    end else if (fall_evt) begin
                        fill_cnt_r <= fill_cnt_r + 2'h1;
                        if (fill_cnt_r == 2'(LATENCY_CYC - 1)) begin
                            state_r <= ST_RUN;
                        end
                    end
                end
                ST_RUN: begin
                    if (sleep_lvl_r) begin
                        state_r <= ST_SLEEP;
                    end
                end
                default: state_r <= ST_SLEEP;
            endcase
        end
    end

    assign running = (state_r != ST_SLEEP) && !sleep_lvl_r;

    // Wake time count, a status hint for the capture side
    always_ff @(posedge clk_i) begin
        if (rst_i || sleep_lvl_r) begin
            wake_cnt_r  <= 10'h000;
            wake_done_o <= 1'b0;
        end else if (wake_cnt_r != 10'(WAKE_TIME_CYC)) begin
            wake_cnt_r  <= wake_cnt_r + 10'h001;
        end else begin
            wake_done_o <= 1'b1;
        end
    end

    // ********************************************************************
    // Sample buffer
    // ********************************************************************
    logic              take;
    logic              fifo_in_ready;
    logic              fifo_out_valid;
    logic [CODE_W-1:0] fifo_out_data;
    logic              pop;

    // capture at falling edge while running
    assign take = running && fall_evt;
    // one word leaves per edge once the pipe is full
    assign pop  = take && (state_r == ST_RUN);

    sample_fifo #(
        .WIDTH (CODE_W),
        .DEPTH (FIFO_DEPTH_P)
    ) u_fifo (
        .clk_i       (clk_i),
        .rst_i       (rst_i || !running),
        .in_valid_i  (take),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   (clamp_code(raw_sample_i)),
        .out_valid_o (fifo_out_valid),
        .out_ready_i (pop),
        .out_data_o  (fifo_out_data)
    );

    // Drain keeps pace with fill, so a refused push marks a lost sample
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            overflow_o <= 1'b0;
        end else if (take && !fifo_in_ready) begin
            overflow_o <= 1'b1;
        end
    end

    // ********************************************************************
    // Output bus
    // ********************************************************************
    // word changes only on the edge, one cycle after detect
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            data_o        <= CODE_ZERO;
            word_strobe_o <= 1'b0;
        end else begin
            word_strobe_o <= pop && fifo_out_valid;
            if (pop && fifo_out_valid) begin
                data_o <= fifo_out_data;
            end
        end
    end

    // drive only when enabled and awake
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            data_oe_o <= {CODE_W{1'b0}};
        end else begin
            data_oe_o <= {CODE_W{!oen_lvl_r && !sleep_lvl_r}};
        end
    end
endmodule

// ************************************************************************
// Sample FIFO, valid/ready on both sides, synchronous active-high reset
// ************************************************************************
module sample_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // Fill side
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // Drain side
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wr_ptr_r;
    logic [AW-1:0]    rd_ptr_r;
    logic [AW:0]      count_r;
    logic             push;
    logic             pop;

    assign in_ready_o  = (count_r != (AW+1)'(DEPTH));
    assign out_valid_o = (count_r != '0);
    assign out_data_o  = mem_r[rd_ptr_r];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
            end
            count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// [src/conv_port_pkg.sv]
/*
 * Shared constants and types for the converter output port: code width,
 * saturation codes, pipeline latency, timing figures and the sample carrier.
 * Assumes a single 20 MHz system clock and a synchronous active-high reset.
 */
package conv_port_pkg;

    localparam int          CODE_W          = 10;
    localparam logic [9:0]  CODE_ZERO       = 10'h000;
    localparam logic [9:0]  CODE_FULL       = 10'h3FF;
    localparam int          CODE_MAX        = 1023;
    localparam int          LATENCY_CYC     = 2;
    localparam int          CLK_PERIOD_NS   = 50;
    localparam int          MAX_RATE_MSPS   = 30;
    localparam int          OUT_DELAY_NS    = 25;
    localparam int          OUT_DELAY_CYC   =
        (OUT_DELAY_NS / CLK_PERIOD_NS) < 1 ? 1 : (OUT_DELAY_NS / CLK_PERIOD_NS);
    localparam int          WAKE_TIME_NS    = 700;
    localparam int          WAKE_TIME_CYC   =
        (WAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          FIFO_DEPTH      = 16;
    localparam logic [10:0] RAW_SPAN_TOP    = 11'h3_FF;
    localparam int          RAW_W           = 12;

    // Raw quantiser result with range flags
    typedef struct packed {
        logic              under;
        logic              over;
        logic [CODE_W-1:0] code;
    } sample_type;

    typedef enum logic [1:0] {
        ST_SLEEP,
        ST_FILL,
        ST_RUN
    } run_state_type;

endpackage

// [src/sample_fifo.sv]
/*
 * Holds no logic: the sample FIFO module is declared in the same file as the
 * converter output port, which keeps all of the block's logic in one file.
 * Assumes nothing of its surroundings.
 */

// [sim/conv_port_asserts.sv]
/* Checker on the converter port pins.
   Assumes a conversion clock half period of 10 clk or more. */
module conv_port_checker
    import conv_port_pkg::*;
#(
    parameter int FIFO_DEPTH_P = 16
) (
    // Clock, reset, pins
    input wire logic                       clk_i,
    input wire logic                       rst_i,
    input wire logic                       conv_clk_i,
    input wire logic                       sleep_request_i,
    input wire logic                       out_enable_n_i,
    input wire conv_port_pkg::sample_type  raw_sample_i,
    // Outputs
    input wire logic [conv_port_pkg::CODE_W-1:0] data_o,
    input wire logic [conv_port_pkg::CODE_W-1:0] data_oe_o,
    input wire logic                       word_strobe_o,
    input wire logic                       wake_done_o,
    input wire logic                       overflow_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] falls_r;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Falls since wake; the first two only fill the pipe
    always_ff @(posedge clk_i) begin
        if (rst_i || sleep_request_i) begin
            falls_r <= 2'h0;
        end else if ($fell(conv_clk_i) && falls_r != 2'h3) begin
            falls_r <= falls_r + 2'h1;
        end
    end
    sequence fall_seen;
        $fell(conv_clk_i) && !sleep_request_i && falls_r >= 2'h2;
    endsequence
    word_due_a: assert property (fall_seen |-> ##[2:8] word_strobe_o)
        else $error("word late");
    word_first_a: assert property (word_strobe_o |-> falls_r == 2'h3)
        else $error("word too early");
    strobe_gap_a: assert property (word_strobe_o |=> !word_strobe_o)
        else $error("strobe held");
    word_hold_a: assert property (!$stable(data_o) |-> word_strobe_o)
        else $error("word changed alone");
    stall_quiet_a: assert property ($stable(conv_clk_i) [*8] |-> !word_strobe_o)
        else $error("word with clock stopped");
    sleep_quiet_a: assert property (sleep_request_i [*8] |-> !word_strobe_o)
        else $error("word while asleep");
    oe_drive_a: assert property ((!out_enable_n_i && !sleep_request_i) [*8]
        |-> data_oe_o == CODE_FULL) else $error("bus not driven");
    oe_float_a: assert property ((out_enable_n_i || sleep_request_i) [*8]
        |-> data_oe_o == CODE_ZERO) else $error("bus not floated");
endmodule

bind conv_output_port conv_port_checker #(.FIFO_DEPTH_P(FIFO_DEPTH_P)) chk_u (
    .clk_i(clk_i), .rst_i(rst_i), .conv_clk_i(conv_clk_i),
    .sleep_request_i(sleep_request_i), .out_enable_n_i(out_enable_n_i),
    .raw_sample_i(raw_sample_i), .data_o(data_o), .data_oe_o(data_oe_o),
    .word_strobe_o(word_strobe_o), .wake_done_o(wake_done_o), .overflow_o(overflow_o));

// [sim/capture_model.sv]
/* Capture-side model: makes the conversion clock, still while stopped.
   Assumes clk_i is the system clock and sleep_i the power-down pin. */
module capture_model
    import conv_port_pkg::*;
#(
    parameter int HALF_P = 10
) (
    // Clock and control
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic run_i,
    input  wire logic sleep_i,
    // Conversion clock and edge marks
    output logic      conv_clk_o,
    output logic      fall_o,
    output logic      rise_o
);
    timeunit 1ns;
    timeprecision 1ns;
    int wake_r;
    int phase_r;
    always @(posedge clk_i) begin
        fall_o <= 1'b0;
        rise_o <= 1'b0;
        wake_r <= (rst_i || sleep_i) ? 0 : wake_r + 1;
        // clock parked high until wake time passes
        if (!run_i || wake_r < WAKE_TIME_CYC) begin
            phase_r <= 0;
            conv_clk_o <= 1'b1;
        end else if (phase_r == HALF_P - 1) begin
            phase_r <= 0;
            conv_clk_o <= !conv_clk_o;
            fall_o <= conv_clk_o;
            rise_o <= !conv_clk_o;
        end else begin
            phase_r <= phase_r + 1;
        end
    end
endmodule

// [sim/testbench.sv]
/* Self-checking bench for conv_output_port with the capture model.
   Assumes raw samples stay stable while the conversion clock is low. */
module testbench;
    import conv_port_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic              clk_i = 1'b0;
    logic              rst_i = 1'b1;
    logic              run_r = 1'b0;
    logic              sleep_r = 1'b1;
    logic              oe_n_r = 1'b1;
    sample_type        raw_r = '0;
    logic              conv_w, fall_w, rise_w, strobe_w, wake_w, ovf_w;
    logic [CODE_W-1:0] data_w, oe_w;
    logic [CODE_W-1:0] exp_q[$];
    int                num_errors = 0;
    int                checked = 0;
    int                seed = 6;

    capture_model #(.HALF_P(10)) model_u (.clk_i(clk_i), .rst_i(rst_i), .run_i(run_r),
        .sleep_i(sleep_r), .conv_clk_o(conv_w), .fall_o(fall_w), .rise_o(rise_w));
    conv_output_port #(.FIFO_DEPTH_P(FIFO_DEPTH)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
        .conv_clk_i(conv_w), .sleep_request_i(sleep_r), .out_enable_n_i(oe_n_r),
        .raw_sample_i(raw_r), .data_o(data_w), .data_oe_o(oe_w), .word_strobe_o(strobe_w),
        .wake_done_o(wake_w), .overflow_o(ovf_w));

    initial begin
        forever #25 clk_i = ~clk_i;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        if (num_errors == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Bounded wait for n marks of the chosen conversion clock edge
    task automatic wait_ev(input bit on_rise, input int n);
        int i;
        i = 0;
        while (n > 0) begin
            @(posedge clk_i);
            if ((on_rise ? rise_w : fall_w) === 1'b1) n--;
            i++;
            if (i > 2000) begin
                num_errors++;
                end_sim();
            end
        end
    endtask

    function automatic logic [CODE_W-1:0] expect_word(input sample_type s);
        if (s.under) return CODE_ZERO;
        if (s.over) return CODE_FULL;
        return s.code;
    endfunction

    // Raw value moves only while the conversion clock is high
    always @(posedge clk_i) begin
        if (rise_w === 1'b1) raw_r <= sample_type'(12'($random(seed)));
        // word taken at the falling edge
        if (fall_w === 1'b1) exp_q.push_back(expect_word(raw_r));
        if (strobe_w === 1'b1) begin
            if (exp_q.size() == 0) check(32'h0000_0001, 32'h0000_0000);
            else check(32'(data_w), 32'(exp_q.pop_front()));
        end
    end

    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            {sleep_r, oe_n_r} <= 2'(i);
            repeat (30) @(posedge clk_i);
            check(32'(oe_w), (i == 0) ? 32'h0000_03FF : 32'h0000_0000);
        end
        {sleep_r, oe_n_r, run_r} <= 3'h1;
        wait_ev(1'b0, 24);
        run_r <= 1'b0;
        repeat (60) @(posedge clk_i);
        run_r <= 1'b1;
        wait_ev(1'b0, 8);
        wait_ev(1'b1, 1);
        sleep_r <= 1'b1;
        // sleep drops the two words in flight
        exp_q.delete();
        repeat (40) @(posedge clk_i);
        check(32'(wake_w), 32'h0000_0000);
        sleep_r <= 1'b0;
        wait_ev(1'b0, 12);
        run_r <= 1'b0;
        repeat (40) @(posedge clk_i);
        check(exp_q.size(), 32'h0000_0002);
        check(32'(wake_w), 32'h0000_0001);
        check(32'(ovf_w), 32'h0000_0000);
        end_sim();
    end

    initial begin
        repeat (100000) @(posedge clk_i);
        num_errors++;
        end_sim();
    end
endmodule
